// *** core/dual_serial_host_interface.v ***
// Dual serial host interface: APB registers, vectored daisy-chain interrupts, wait/ready
`timescale 1ns/100ps
`include "serial_host_consts.vh"
module dual_serial_host_interface (
  input wire clock,
  input wire reset,
  input wire clockEnable,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [1:0] rxCharValid,
  input wire [15:0] rxChar,
  input wire [1:0] rxParityErr,
  input wire [1:0] rxFrameErr,
  input wire [1:0] rxEndOfFrame,
  input wire [1:0] txShiftReady,
  input wire [1:0] ctsIn,
  input wire [1:0] carrier_detect_in,
  input wire [1:0] syncIn,
  input wire [1:0] breakAbortIn,
  input wire [1:0] crcSendingIn,
  input wire [1:0] txUnderrunIn,
  output wire [1:0] txLoad,
  output wire [39:0] txShift,
  input wire opFetchN,
  input wire intAckN,
  input wire opValid,
  input wire [7:0] opByte,
  input wire chain_enable_in,
  output wire chain_enable_out,
  output wire intReqOut,
  output wire intReqOe,
  output reg [7:0] vectorOut,
  output reg vectorValid,
  output wire [1:0] waitReadyOut,
  output wire [1:0] waitReadyOe
);
  wire [7:0] rdA, rdB, modeA, modeB, vecB;
  // Channel A copy of the vector register is never read
  wire [15:0] modeBus, vecBus;
  wire [5:0] ptrBus;
  wire [`SRC_COUNT*2-1:0] pendView;
  reg [`SRC_COUNT*2-1:0] pendHeld_reg;
  wire [2:0] ptrA, ptrB;
  wire [1:0] rxAvail, txEmpty;
  wire [`SRC_COUNT*2-1:0] pend;
  reg [`SRC_COUNT*2-1:0] service_reg;
  reg [`SRC_COUNT*2-1:0] ack;
  reg prefixSeen_reg;
  reg [7:0] modVector;
  reg [3:0] winner;
  reg anyPend;
  wire apbWr, apbRd, mapped;
  wire [7:0] regOut [0:1];
  wire [1:0] wrStb, rdStb;
  wire [2:0] selOut [0:1];
  integer k;

  assign apbWr = psel && penable && pwrite;
  assign apbRd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign mapped = paddr <= `ADDR_RXIN_B && paddr[1:0] == 2'h0;
  assign pslverr = psel && penable && !mapped;

  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : chan
      wire isCmd, isData;
      assign isCmd = paddr == (c ? `ADDR_CMD_B : `ADDR_CMD_A);
      assign isData = paddr == (c ? `ADDR_DATA_B : `ADDR_DATA_A);
      // A pointer-2 write on A lands in the unread copy, so the pointer still returns
      assign wrStb[c] = apbWr && (isCmd || isData);
      assign rdStb[c] = apbRd && (isCmd || isData);
      assign selOut[c] = isData ? 3'h7 : (c ? ptrB : ptrA);
      // Wait/ready: enable, function, direction bits
      wire [7:0] m;
      wire able;
      assign m = c ? modeB : modeA;
      assign able = m[`WR1_WR_ON_RX] ? rxAvail[c] : txEmpty[c];
      assign waitReadyOut[c] = m[`WR1_WR_FUNC] ? !able : 1'b0;
      assign waitReadyOe[c] = m[`WR1_WR_EN] && (m[`WR1_WR_FUNC] || !able);
      serial_channel #(.DEPTH(`RX_FIFO_DEPTH)) unit (
        .clock(clock),
        .reset(reset),
        .clockEnable(clockEnable),
        .regSel(selOut[c]),
        .dataSel(isData),
        .wrStrobe(wrStb[c]),
        .rdStrobe(rdStb[c]),
        .wrData(pwdata[7:0]),
        .vectorIn(modVector),
        .rxCharValid(rxCharValid[c]),
        .rxChar(rxChar[c*8 +: 8]),
        .rxParityErr(rxParityErr[c]),
        .rxFrameErr(rxFrameErr[c]),
        .rxEndOfFrame(rxEndOfFrame[c]),
        .txShiftReady(txShiftReady[c]),
        .ctsIn(ctsIn[c]),
        .carrierDetectIn(carrier_detect_in[c]),
        .syncIn(syncIn[c]),
        .breakAbortIn(breakAbortIn[c]),
        .crcSendingIn(crcSendingIn[c]),
        .txUnderrunIn(txUnderrunIn[c]),
        .ackRx(ack[c*`SRC_COUNT + 0]),
        .ackSpecial(ack[c*`SRC_COUNT + 1]),
        .ackTx(ack[c*`SRC_COUNT + 2]),
        .ackExt(ack[c*`SRC_COUNT + 3]),
        .regRdData(regOut[c]),
        .ctrlMode(modeBus[c*8 +: 8]),
        .vectorReg(vecBus[c*8 +: 8]),
        .rxPend(pend[c*`SRC_COUNT + 0]),
        .specialPend(pend[c*`SRC_COUNT + 1]),
        .txPend(pend[c*`SRC_COUNT + 2]),
        .extPend(pend[c*`SRC_COUNT + 3]),
        .txLoad(txLoad[c]),
        .txShift(txShift[c*20 +: 20]),
        .rxAvail(rxAvail[c]),
        .txEmpty(txEmpty[c]),
        .ptrReg(ptrBus[c*3 +: 3])
      );
      assign pend[c*`SRC_COUNT + 5 : c*`SRC_COUNT + 4] = 2'h0;
    end
  endgenerate
  assign rdA = regOut[0];
  assign rdB = regOut[1];
  assign modeA = modeBus[7:0];
  assign modeB = modeBus[15:8];
  assign vecB = vecBus[15:8];
  assign ptrA = ptrBus[2:0];
  assign ptrB = ptrBus[5:3];

  // Snapshot while fetch is high; a source arriving mid-acknowledge waits
  assign pendView = opFetchN ? pend : pendHeld_reg;
  always @(posedge clock) begin
    if (reset) pendHeld_reg <= {`SRC_COUNT*2{1'b0}};
    else if (clockEnable && opFetchN) pendHeld_reg <= pend;
  end

  // Priority: A before B; within channel rx, then special, then tx, then ext
  always @* begin
    winner = 4'hf;
    for (k = `SRC_COUNT*2 - 1; k >= 0; k = k - 1) begin
      if (pendView[k] && (k % `SRC_COUNT) < 4) winner = k[3:0];
    end
    anyPend = (winner != 4'hf);
  end

  // Vector modification: bits 3:1 from channel and source
  always @* begin
    modVector = vecB;
    if (modeB[`WR1_STAT_AFFECTS_VEC]) begin
      case (winner)
        4'h0: modVector[3:1] = 3'h6;
        4'h1: modVector[3:1] = 3'h7;
        4'h2: modVector[3:1] = 3'h4;
        4'h3: modVector[3:1] = 3'h5;
        4'h6: modVector[3:1] = 3'h2;
        4'h7: modVector[3:1] = 3'h3;
        4'h8: modVector[3:1] = 3'h0;
        4'h9: modVector[3:1] = 3'h1;
        default: modVector[3:1] = 3'h3;
      endcase
    end
  end

  wire anyService;
  wire ackCycle;
  assign anyService = |service_reg;
  // Pending is masked off the chain once the prefix opcode is seen
  assign chain_enable_out = chain_enable_in && !anyService
    && !(anyPend && !prefixSeen_reg);
  assign intReqOut = 1'b0;
  assign intReqOe = anyPend && chain_enable_in && !anyService;
  assign ackCycle = !opFetchN && !intAckN;

  always @(posedge clock) begin
    if (reset) begin
      service_reg <= {`SRC_COUNT*2{1'b0}};
      prefixSeen_reg <= 1'b0;
      vectorOut <= 8'h00;
      vectorValid <= 1'b0;
      ack <= {`SRC_COUNT*2{1'b0}};
    end else if (clockEnable) begin
      ack <= {`SRC_COUNT*2{1'b0}};
      vectorValid <= 1'b0;
      if (ackCycle && chain_enable_in && anyPend && !anyService) begin
        vectorOut <= modVector;
        vectorValid <= 1'b1;
        service_reg[winner] <= 1'b1;
        ack[winner] <= 1'b1;
      end else if (opValid) begin
        // Opcodes arrive with fetch low, so decoding is not frozen
        if (opByte == `OP_PREFIX) prefixSeen_reg <= 1'b1;
        else begin
          if (prefixSeen_reg && opByte == `OP_RETURN && chain_enable_in)
            service_reg <= {`SRC_COUNT*2{1'b0}};
          prefixSeen_reg <= 1'b0;
        end
      end
    end
  end

  // APB read data, registered on the setup cycle
  always @(posedge clock) begin
    if (reset) prdata <= 32'h00000000;
    else if (clockEnable && psel && !penable) begin
      case (paddr)
        `ADDR_CMD_A, `ADDR_DATA_A: prdata <= {24'h000000, rdA};
        `ADDR_CMD_B, `ADDR_DATA_B: prdata <= {24'h000000, rdB};
        `ADDR_EVENT_A: prdata <= {26'h0, pend[5:0]};
        `ADDR_EVENT_B: prdata <= {26'h0, pend[11:6]};
        `ADDR_IRQCTL: prdata <= {20'h00000, service_reg};
        `ADDR_TXOUT_A: prdata <= {30'h0, txEmpty[0], rxAvail[0]};
        `ADDR_TXOUT_B: prdata <= {30'h0, txEmpty[1], rxAvail[1]};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
endmodule

// *** shared/serial_host_consts.vh ***
// Constants for the dual serial host interface block
`ifndef SERIAL_HOST_CONSTS_VH
`define SERIAL_HOST_CONSTS_VH
`define ADDR_CMD_A 12'h000
`define ADDR_CMD_B 12'h004
`define ADDR_DATA_A 12'h008
`define ADDR_DATA_B 12'h00c
`define ADDR_EVENT_A 12'h010
`define ADDR_EVENT_B 12'h014
`define ADDR_IRQCTL 12'h018
`define ADDR_TXOUT_A 12'h01c
`define ADDR_TXOUT_B 12'h020
`define ADDR_RXIN_A 12'h024
`define ADDR_RXIN_B 12'h028
`define PTR_LSB 0
`define PTR_MSB 2
`define PTR_RESET 3'h0
`define VECTOR_RESET 8'h00
`define WR1_EXT_IE 0
`define WR1_TX_IE 1
`define WR1_STAT_AFFECTS_VEC 2
`define WR1_RX_MODE_LSB 3
`define WR1_RX_MODE_MSB 4
`define WR1_WR_ON_RX 5
`define WR1_WR_FUNC 6
`define WR1_WR_EN 7
`define RXM_OFF 2'h0
`define RXM_FIRST 2'h1
`define RXM_ALL_PAR 2'h2
`define RXM_ALL 2'h3
`define RR0_RX_AVAIL 0
`define RR0_IRQ_PEND 1
`define RR0_TX_EMPTY 2
`define RR0_DCD 3
`define RR0_SYNC 4
`define RR0_CTS 5
`define RR0_TX_UNDERRUN 6
`define RR0_BREAK 7
`define RR1_PARITY 4
`define RR1_OVERRUN 5
`define RR1_CRC_FRAMING 6
`define RR1_END_OF_FRAME 7
`define OP_PREFIX 8'hed
`define OP_RETURN 8'h4d
`define RX_FIFO_DEPTH 3
`define TX_SHIFT_WIDTH 20
`define SRC_COUNT 6
`endif

// *** core/serial_channel.v ***
// One channel: register set, receive queue, transmit buffer and event sources
`timescale 1ns/100ps
`include "serial_host_consts.vh"
module serial_channel #(
  parameter DEPTH = `RX_FIFO_DEPTH
) (
  input wire clock,
  input wire reset,
  input wire clockEnable,
  input wire [2:0] regSel,
  input wire dataSel,
  input wire wrStrobe,
  input wire rdStrobe,
  input wire [7:0] wrData,
  input wire [7:0] vectorIn,
  input wire rxCharValid,
  input wire [7:0] rxChar,
  input wire rxParityErr,
  input wire rxFrameErr,
  input wire rxEndOfFrame,
  input wire txShiftReady,
  input wire ctsIn,
  input wire carrierDetectIn,
  input wire syncIn,
  input wire breakAbortIn,
  input wire crcSendingIn,
  input wire txUnderrunIn,
  input wire ackRx,
  input wire ackSpecial,
  input wire ackTx,
  input wire ackExt,
  output reg [7:0] regRdData,
  output reg [7:0] ctrlMode,
  output reg [7:0] vectorReg,
  output reg rxPend,
  output reg specialPend,
  output reg txPend,
  output reg extPend,
  output reg txLoad,
  output reg [`TX_SHIFT_WIDTH-1:0] txShift,
  output wire rxAvail,
  output wire txEmpty,
  output reg [2:0] ptrReg
);
  reg [7:0] rxParam, miscParam, txParam, syncLow, syncHigh;
  reg [7:0] rxData [0:DEPTH-1];
  reg [DEPTH-1:0] rxParity, rxFrame, rxEof;
  reg [1:0] rxCount;
  reg [7:0] txBuf;
  reg txFull, txWritten, firstSeen, overrunFlag, breakPrev;
  reg [2:0] extPrev;
  wire [2:0] extNow;
  wire [1:0] rxMode;
  wire rxPop, rxPush, breakEdge;
  wire specialCond;
  integer i;

  assign rxMode = ctrlMode[`WR1_RX_MODE_MSB:`WR1_RX_MODE_LSB];
  assign rxAvail = (rxCount != 2'h0);
  assign txEmpty = !txFull;
  assign extNow = {syncIn, carrierDetectIn, ctsIn};
  // Data port has its own select, so pointer 7 still reaches its register
  assign rxPop = rdStrobe && dataSel && rxAvail;
  assign rxPush = rxCharValid && (rxCount != DEPTH[1:0] || rxPop);
  assign breakEdge = breakAbortIn != breakPrev;
  assign specialCond = rxCharValid && (rxFrameErr || rxEndOfFrame
    || (rxParityErr && rxMode == `RXM_ALL_PAR) || (rxCount == DEPTH[1:0] && !rxPop));

  always @* begin
    case (regSel)
      3'h0: regRdData = {breakAbortIn, txUnderrunIn, ctsIn, syncIn, carrierDetectIn,
        txEmpty, rxPend | txPend | extPend | specialPend, rxAvail};
      3'h1: regRdData = {rxEof[0], rxFrame[0], overrunFlag, rxParity[0], 4'h1};
      3'h2: regRdData = vectorIn;
      default: regRdData = 8'h00;
    endcase
    if (dataSel) regRdData = rxData[0];
  end

  always @(posedge clock) begin
    if (reset) begin
      ptrReg <= `PTR_RESET;
      ctrlMode <= 8'h00;
      vectorReg <= `VECTOR_RESET;
      rxParam <= 8'h00;
      miscParam <= 8'h00;
      txParam <= 8'h00;
      syncLow <= 8'h00;
      syncHigh <= 8'h00;
      rxCount <= 2'h0;
      rxParity <= {DEPTH{1'b0}};
      rxFrame <= {DEPTH{1'b0}};
      rxEof <= {DEPTH{1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) rxData[i] <= 8'h00;
      txBuf <= 8'h00;
      txFull <= 1'b0;
      txWritten <= 1'b0;
      txLoad <= 1'b0;
      txShift <= {`TX_SHIFT_WIDTH{1'b0}};
      firstSeen <= 1'b0;
      overrunFlag <= 1'b0;
      rxPend <= 1'b0;
      specialPend <= 1'b0;
      txPend <= 1'b0;
      extPend <= 1'b0;
      extPrev <= 3'h0;
    end else if (clockEnable) begin
      txLoad <= 1'b0;
      extPrev <= extNow;
      if (wrStrobe && !dataSel) begin
        case (ptrReg)
          3'h0: ptrReg <= wrData[`PTR_MSB:`PTR_LSB];
          3'h1: ctrlMode <= wrData;
          3'h2: vectorReg <= wrData;
          3'h3: rxParam <= wrData;
          3'h4: miscParam <= wrData;
          3'h5: txParam <= wrData;
          3'h6: syncLow <= wrData;
          default: syncHigh <= wrData;
        endcase
        if (ptrReg != 3'h0) ptrReg <= `PTR_RESET;
        if (ptrReg == 3'h0 && wrData[5:3] == 3'h2) firstSeen <= 1'b0;
      end else if (rdStrobe && !dataSel && regSel != 3'h0) begin
        ptrReg <= `PTR_RESET;
      end
      // Receive queue, shifted on pop
      if (rxPop) begin
        for (i = 0; i < DEPTH - 1; i = i + 1) begin
          rxData[i] <= rxData[i+1];
          rxParity[i] <= rxParity[i+1];
          rxFrame[i] <= rxFrame[i+1];
          rxEof[i] <= rxEof[i+1];
        end
      end
      if (rxPush) begin
        rxData[rxPop ? rxCount - 2'h1 : rxCount] <= rxChar;
        rxParity[rxPop ? rxCount - 2'h1 : rxCount] <= rxParityErr;
        rxFrame[rxPop ? rxCount - 2'h1 : rxCount] <= rxFrameErr;
        rxEof[rxPop ? rxCount - 2'h1 : rxCount] <= rxEndOfFrame;
      end
      if (rxPush && !rxPop) rxCount <= rxCount + 2'h1;
      else if (rxPop && !rxPush) rxCount <= rxCount - 2'h1;
      if (rxCharValid && rxCount == DEPTH[1:0] && !rxPop) overrunFlag <= 1'b1;
      else if (rdStrobe && regSel == 3'h1) overrunFlag <= 1'b0;
      // Receive interrupt sources; set wins over acknowledge
      if (rxCharValid && (rxMode == `RXM_ALL || rxMode == `RXM_ALL_PAR
          || (rxMode == `RXM_FIRST && !firstSeen))) rxPend <= 1'b1;
      else if (ackRx) rxPend <= 1'b0;
      if (rxCharValid && rxMode == `RXM_FIRST) firstSeen <= 1'b1;
      if (rxMode != `RXM_OFF && specialCond
          && !(rxMode == `RXM_FIRST && rxParityErr && !rxFrameErr && !rxEndOfFrame
          && rxCount != DEPTH[1:0])) specialPend <= 1'b1;
      else if (ackSpecial) specialPend <= 1'b0;
      // Transmit buffer and shift register
      if (wrStrobe && dataSel) begin
        txBuf <= wrData;
        txFull <= 1'b1;
        txWritten <= 1'b1;
      end else if (txFull && txShiftReady) begin
        txShift <= {syncHigh, syncLow[3:0], txBuf};
        txLoad <= 1'b1;
        txFull <= 1'b0;
      end
      if (txFull && txShiftReady && ctrlMode[`WR1_TX_IE] && txWritten) txPend <= 1'b1;
      else if (ackTx || (wrStrobe && dataSel)) txPend <= 1'b0;
      // External/status: pin transitions, break/abort both edges, CRC sending
      if (ctrlMode[`WR1_EXT_IE] && ((extNow != extPrev) || crcSendingIn || breakEdge))
        extPend <= 1'b1;
      else if (ackExt) extPend <= 1'b0;
    end
  end

  always @(posedge clock) begin
    if (reset) breakPrev <= 1'b0;
    else if (clockEnable) breakPrev <= breakAbortIn;
  end
endmodule

// *** sim/host_if_asserts.sv ***
// Port checker for the dual serial host interface
`timescale 1ns/100ps
module host_if_asserts (
  input wire clock,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pslverr,
  input wire opFetchN,
  input wire intAckN,
  input wire opValid,
  input wire chain_enable_in,
  input wire chain_enable_out,
  input wire intReqOut,
  input wire intReqOe,
  input wire vectorValid
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence fetchOnly;
    !opFetchN && intAckN && !opValid && !psel;
  endsequence
  sequence fetchHeld;
    fetchOnly ##1 (!opFetchN && intAckN && $stable(chain_enable_in));
  endsequence
  a_chain_pend_low: assert property (intReqOe |-> !chain_enable_out)
    else $error("chain out high while requesting");
  a_chain_follow: assert property (!chain_enable_in |-> !chain_enable_out)
    else $error("chain out high with chain input low");
  a_req_needs_iei: assert property (intReqOe |-> chain_enable_in)
    else $error("request while chain input low");
  a_req_open_drain: assert property (intReqOut == 1'b0)
    else $error("request pin driven high");
  a_vec_after_ack: assert property (vectorValid |-> !$past(intAckN) && !$past(opFetchN))
    else $error("vector without acknowledge");
  a_freeze_fetch: assert property (fetchHeld |-> $stable(chain_enable_out))
    else $error("chain changed during fetch");
  a_err_unmapped: assert property (psel && penable && paddr > 12'h028 |-> pslverr)
    else $error("no error for unmapped address");
  a_err_mapped: assert property (psel && penable && paddr <= 12'h028 &&
    paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("error for mapped address");
endmodule
bind dual_serial_host_interface host_if_asserts host_if_asserts_inst (.clock(clock),
  .reset(reset), .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
  .opFetchN(opFetchN), .intAckN(intAckN), .opValid(opValid),
  .chain_enable_in(chain_enable_in), .chain_enable_out(chain_enable_out),
  .intReqOut(intReqOut), .intReqOe(intReqOe), .vectorValid(vectorValid));

// *** sim/cpu_side_model.sv ***
// Processor-side model: acknowledge and return-from-interrupt bus cycles
`timescale 1ns/100ps
module cpu_side_model (
  input wire clock,
  input wire doAck,
  input wire doRet,
  input wire vectorValid,
  input wire [7:0] vectorOut,
  output reg opFetchN,
  output reg intAckN,
  output reg opValid,
  output reg [7:0] opByte,
  output reg busy,
  output reg [7:0] ackVector,
  output reg [15:0] tableAddr
);
  localparam logic [7:0] PAGE = 8'h3c;
  reg [2:0] step;
  reg isRet;
  initial begin
    opFetchN = 1'b1;
    intAckN = 1'b1;
    opValid = 1'b0;
    opByte = 8'h00;
    busy = 1'b0;
    ackVector = 8'h00;
    tableAddr = 16'h0000;
    step = 3'd0;
    isRet = 1'b0;
  end
  always @(posedge clock) begin
    if (vectorValid) begin
      ackVector <= vectorOut;
      tableAddr <= {PAGE, vectorOut};
    end
    opValid <= 1'b0;
    // Undriven bus: toggles so stale bytes never look valid
    opByte <= ~opByte;
    step <= (step == 3'd0) ? {2'b00, doAck | doRet} : step + 3'd1;
    case (step)
      3'd0: begin
        busy <= doAck | doRet;
        isRet <= doRet;
      end
      3'd1: begin
        opFetchN <= 1'b0;
        opValid <= isRet;
        opByte <= 8'hed;
      end
      3'd2: opFetchN <= isRet;
      3'd3: begin
        // Fetch held low two cycles before acknowledge
        intAckN <= isRet;
        opFetchN <= 1'b0;
        opValid <= isRet;
        opByte <= 8'h4d;
      end
      3'd4: opFetchN <= isRet;
      3'd5: begin
        opFetchN <= 1'b1;
        intAckN <= 1'b1;
      end
      default: begin
        busy <= 1'b0;
        step <= 3'd0;
      end
    endcase
  end
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the dual serial host interface
`timescale 1ns/100ps
`include "serial_host_consts.vh"
module tb;
  typedef struct packed {logic w; logic [11:0] a; logic [7:0] d, m, x; logic e;} row_t;
  reg clock, reset, psel, penable, pwrite, doAck, doRet, chainIn, serr;
  reg [11:0] paddr, extIn;
  reg [31:0] pwdata, rdata;
  reg [1:0] rxCharValid, txShiftReady;
  reg [15:0] rxChar;
  reg [7:0] v1;
  wire [31:0] prdata;
  wire pready, pslverr, opFetchN, intAckN, opValid, chainOut, intReqOut, intReqOe;
  wire vectorValid, busy;
  wire [7:0] opByte, vectorOut, ackVector;
  wire [1:0] txLoad, waitReadyOut, waitReadyOe;
  wire [39:0] txShift;
  wire [15:0] tableAddr;
  integer err_total = 0, samples_checked = 0, i, k;
  row_t rows [0:10] = '{'{1'b1, 12'h004, 8'h02, 8'h00, 8'h00, 1'b0},
    '{1'b1, 12'h004, 8'h5a, 8'h00, 8'h00, 1'b0}, '{1'b1, 12'h004, 8'h02, 8'h00, 8'h00, 1'b0},
    '{1'b0, 12'h004, 8'h00, 8'hff, 8'h5a, 1'b0}, '{1'b1, 12'h000, 8'h02, 8'h00, 8'h00, 1'b0},
    '{1'b1, 12'h000, 8'ha5, 8'h00, 8'h00, 1'b0}, '{1'b1, 12'h004, 8'h02, 8'h00, 8'h00, 1'b0},
    '{1'b0, 12'h004, 8'h00, 8'hff, 8'h5a, 1'b0}, '{1'b0, 12'h000, 8'h00, 8'h29, 8'h20, 1'b0},
    '{1'b1, 12'h02c, 8'h00, 8'h00, 8'h00, 1'b1}, '{1'b0, 12'h002, 8'h00, 8'h00, 8'h00, 1'b1}};
  dual_serial_host_interface dual_serial_host_interface_inst (.clock(clock), .reset(reset),
    .clockEnable(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxCharValid(rxCharValid), .rxChar(rxChar), .rxParityErr(2'b00), .rxFrameErr(2'b00),
    .rxEndOfFrame(2'b00), .txShiftReady(txShiftReady), .ctsIn(extIn[1:0]),
    .carrier_detect_in(extIn[3:2]), .syncIn(extIn[5:4]), .breakAbortIn(extIn[7:6]),
    .crcSendingIn(extIn[9:8]), .txUnderrunIn(extIn[11:10]), .txLoad(txLoad),
    .txShift(txShift), .opFetchN(opFetchN), .intAckN(intAckN), .opValid(opValid),
    .opByte(opByte), .chain_enable_in(chainIn), .chain_enable_out(chainOut),
    .intReqOut(intReqOut), .intReqOe(intReqOe), .vectorOut(vectorOut),
    .vectorValid(vectorValid), .waitReadyOut(waitReadyOut), .waitReadyOe(waitReadyOe));
  cpu_side_model cpu_side_model_inst (.clock(clock), .doAck(doAck), .doRet(doRet),
    .vectorValid(vectorValid), .vectorOut(vectorOut), .opFetchN(opFetchN),
    .intAckN(intAckN), .opValid(opValid), .opByte(opByte), .busy(busy),
    .ackVector(ackVector), .tableAddr(tableAddr));
  task automatic print_verdict;
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string what, input reg [31:0] exp, input reg [31:0] got);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic timed_out(input integer n);
    if (n >= 40) begin
      err_total = err_total + 1;
      print_verdict();
    end
  endtask
  task automatic do_reset;
    reset <= 1'b1;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
  endtask
  task automatic apb(input reg w, input reg [11:0] a, input reg [7:0] d);
    integer n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n = n + 1;
    end while (pready !== 1'b1 && n < 40);
    timed_out(n);
    rdata = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic cmd(input reg [11:0] a, input reg [7:0] p, input reg [7:0] d);
    apb(1'b1, a, p);
    apb(1'b1, a, d);
  endtask
  task automatic bus_cycle(input reg ret);
    doAck <= !ret;
    doRet <= ret;
    @(posedge clock);
    doAck <= 1'b0;
    doRet <= 1'b0;
    k = 0;
    do begin
      @(posedge clock);
      k = k + 1;
    end while (busy === 1'b1 && k < 40);
    timed_out(k);
  endtask
  task automatic push(input reg [1:0] ch, input reg [15:0] c);
    rxChar <= c;
    rxCharValid <= ch;
    @(posedge clock);
    rxCharValid <= 2'b00;
    repeat (3) @(posedge clock);
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    {doAck, doRet, chainIn, rxCharValid, rxChar} = 21'h0;
    txShiftReady = 2'b11;
    extIn = 12'h001;
    do_reset();
    chainIn <= 1'b1;
    // Interrupts all off here: polled access only
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      check("pslverr", rows[i].e, serr);
      if (!rows[i].w) check("readback", rows[i].x, rdata[7:0] & rows[i].m);
    end
    rxCharValid <= 2'b01;
    for (i = 0; i < 3; i++) begin
      rxChar <= 16'h0031 + i[15:0];
      @(posedge clock);
    end
    rxCharValid <= 2'b00;
    apb(1'b0, `ADDR_CMD_A, 8'h00);
    check("rx avail", 1, rdata[0]);
    for (i = 0; i < 3; i++) begin
      apb(1'b0, `ADDR_DATA_A, 8'h00);
      check("fifo", 8'h31 + i[7:0], rdata[7:0]);
    end
    apb(1'b0, `ADDR_CMD_A, 8'h00);
    check("rx drained", 0, rdata[0]);
    cmd(`ADDR_CMD_B, 8'h01, 8'h1c);
    cmd(`ADDR_CMD_A, 8'h01, 8'h1c);
    push(2'b11, 16'h4241);
    check("irq", 1, intReqOe);
    check("chain out", 0, chainOut);
    bus_cycle(1'b0);
    v1 = ackVector;
    check("vector", 8'h50, v1 & 8'hf1);
    apb(1'b0, `ADDR_DATA_A, 8'h00);
    bus_cycle(1'b1);
    bus_cycle(1'b0);
    check("vector differs", 1, v1 !== ackVector);
    apb(1'b0, `ADDR_DATA_B, 8'h00);
    bus_cycle(1'b1);
    check("irq done", 0, intReqOe);
    check("chain idle", 1, chainOut);
    cmd(`ADDR_CMD_A, 8'h01, 8'h0c);
    push(2'b01, 16'h0061);
    bus_cycle(1'b0);
    apb(1'b0, `ADDR_DATA_A, 8'h00);
    bus_cycle(1'b1);
    push(2'b01, 16'h0062);
    check("first only", 0, intReqOe);
    apb(1'b0, `ADDR_DATA_A, 8'h00);
    cmd(`ADDR_CMD_A, 8'h01, 8'h02);
    check("tx unwritten", 0, intReqOe);
    apb(1'b1, `ADDR_DATA_A, 8'hc3);
    k = 0;
    while (txLoad[0] !== 1'b1 && k < 40) begin
      @(posedge clock);
      k = k + 1;
    end
    timed_out(k);
    repeat (3) @(posedge clock);
    check("tx empty irq", 1, intReqOe);
    check("tx shift", 8'hc3, txShift[7:0]);
    cmd(`ADDR_CMD_A, 8'h01, 8'hc0);
    check("ready oe", 1, waitReadyOe[0]);
    check("ready out", 0, waitReadyOut[0]);
    cmd(`ADDR_CMD_A, 8'h01, 8'h80);
    check("wait idle", 0, waitReadyOe[0]);
    txShiftReady <= 2'b10;
    apb(1'b1, `ADDR_DATA_A, 8'h55);
    check("wait held", 1, waitReadyOe[0]);
    check("wait out", 0, waitReadyOut[0]);
    txShiftReady <= 2'b11;
    for (i = 0; i < 5; i++) begin
      do_reset();
      cmd(`ADDR_CMD_B, 8'h01, 8'h01);
      check("ext quiet", 0, intReqOe);
      extIn[2 * i + 1] <= ~extIn[2 * i + 1];
      repeat (3) @(posedge clock);
      check("ext irq", 1, intReqOe);
    end
    apb(1'b1, `ADDR_CMD_A, 8'h01);
    do_reset();
    apb(1'b0, `ADDR_CMD_A, 8'h00);
    check("pointer reset", 8'h20, rdata[7:0] & 8'h20);
    print_verdict();
  end
endmodule
